// *** core/sdram_cfg_pkg.sv ***
`default_nettype none

package sdram_cfg_pkg;

  // ---------------------------------------------------------------
  // pin and register widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 14;  // address pins a0..a13
  localparam int BANK_W = 3;   // bank pins, also config bits 14..16
  localparam int CFG_W = 17;   // one config register: {bank, address}

  // ---------------------------------------------------------------
  // register select on the bank pins during a config load
  // ---------------------------------------------------------------
  localparam logic [1:0] SEL_BASE = 2'h0;      // base_mode_config
  localparam logic [1:0] SEL_EXTENDED = 2'h1;  // extended_mode_config

  // values after reset (no documented reset, so all zero)
  localparam logic [CFG_W-1:0] BASE_RST = 17'h00000;
  localparam logic [CFG_W-1:0] EXT_RST = 17'h00000;

  // ---------------------------------------------------------------
  // field positions, base_mode_config
  // ---------------------------------------------------------------
  localparam int RL_CYC_LSB = 4;    // read latency, 3 bits
  localparam int LOOP_RST_BIT = 8;  // clock-alignment loop reset, self clearing
  localparam int WREC_LSB = 9;      // write recovery, 3 bits
  localparam int SLOW_EXIT_BIT = 12;

  // ---------------------------------------------------------------
  // field positions, extended_mode_config
  // ---------------------------------------------------------------
  localparam int LOOP_OFF_BIT = 0;
  localparam int DRIVE_BIT = 1;
  localparam int TERM_LO_BIT = 2;
  localparam int ADD_DLY_LSB = 3;   // added command delay, 3 bits
  localparam int TERM_HI_BIT = 6;
  localparam int COMP_OFF_BIT = 10;
  localparam int DUP_ON_BIT = 11;
  localparam int OUT_OFF_BIT = 12;

  // address bit that marks auto precharge / precharge-all
  localparam int AUTO_PRE_BIT = 10;

  // ---------------------------------------------------------------
  // counts of cycles
  // ---------------------------------------------------------------
  localparam logic [3:0] WREC_OFFSET = 4'h1;  // code 1..7 means 2..8 clocks
  localparam int BURST_CYC = 2;               // four-beat burst, two clocks
  localparam int FAST_EXIT_CYC = 2;           // fast_powerdown_exit_time
  localparam int SLOW_EXIT_CYC = 6;           // slow_powerdown_exit_time
  localparam int DELAY_DEPTH = 32;            // delay line depth; longest pulse delay is 31 clocks

  // command codes on {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_LOAD = 3'h0;
  localparam logic [2:0] CMD_REFRESH = 3'h1;
  localparam logic [2:0] CMD_PRECHARGE = 3'h2;
  localparam logic [2:0] CMD_ACTIVATE = 3'h3;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_READ = 3'h5;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } cmd_pins_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ACTIVE = 6'h02,
    ST_ACT_PD = 6'h04,
    ST_PRE_PD = 6'h08,
    ST_SELF_REF = 6'h10,
    ST_PD_EXIT = 6'h20
  } pwr_state_t;

  typedef enum logic [1:0] {
    TERM_OFF = 2'h0,
    TERM_75 = 2'h1,
    TERM_150 = 2'h2,
    TERM_50 = 2'h3
  } term_sel_t;

  typedef struct packed {
    logic [3:0] write_recovery_time;
    logic [2:0] read_latency_cycles;
    logic [2:0] added_command_delay;
    logic [3:0] effective_read_latency;
    logic [3:0] effective_write_latency;
    logic slow_exit_sel;
  } mode_fields_t;

  typedef struct packed {
    logic drive_reduced;
    logic strobe_comp_en;
    logic dup_strobe_en;
    logic dup_strobe_comp_en;
    logic outputs_enabled;
  } strobe_ctl_t;

endpackage

`default_nettype wire

// *** core/pulse_delay_line.sv ***
`default_nettype none

// ---------------------------------------------------------------
// pulse delay line: a pulse on pulse_in reappears sel_delay clocks
// later on pulse_out; pulses may overlap
// ---------------------------------------------------------------
module pulse_delay_line #(
  parameter int DEPTH = 32
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic pulse_in,
  input wire logic [$clog2(DEPTH)-1:0] sel_delay,
  output logic pulse_out
);

  logic [DEPTH-2:0] stage_ff;  // shift chain, oldest at the top
  logic [DEPTH-1:0] taps;      // tap k is the input delayed k clocks

  assign taps = {stage_ff, pulse_in};

  // shift every clock; the chain never stalls
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stage_ff <= '0;
    end else begin
      stage_ff <= taps[DEPTH-2:0];
    end
  end

  // registered tap: delay 1 means the very next clock
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pulse_out <= 1'b0;
    end else if (sel_delay == '0) begin
      pulse_out <= 1'b0;  // delay 0 is not a legal request
    end else begin
      pulse_out <= taps[sel_delay - 1'b1];
    end
  end

endmodule

`default_nettype wire

// *** core/sdram_mode_config_decode.sv ***
`default_nettype none

module sdram_mode_config_decode #(
  parameter bit X8_CONFIG = 1'b1,
  parameter int FAST_EXIT = sdram_cfg_pkg::FAST_EXIT_CYC,
  parameter int SLOW_EXIT = sdram_cfg_pkg::SLOW_EXIT_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cke_pin,
  input wire sdram_cfg_pkg::cmd_pins_t cmd_pin,
  input wire logic [sdram_cfg_pkg::BANK_W-1:0] bank_pin,
  input wire logic [sdram_cfg_pkg::ADDR_W-1:0] addr_pin,
  input wire logic termination_control,
  output sdram_cfg_pkg::mode_fields_t mode_fields_ff,
  output sdram_cfg_pkg::strobe_ctl_t strobe_ctl_ff,
  output sdram_cfg_pkg::term_sel_t term_sel_ff,
  output logic termination_on_ff,
  output logic loop_enabled_ff,
  output logic loop_running_ff,
  output logic loop_reset_ff,
  output logic auto_precharge_ff,
  output logic read_data_start_ff,
  output logic strobe_drive_ff,
  output logic dup_strobe_drive_ff,
  output sdram_cfg_pkg::pwr_state_t pwr_state_ff,
  output logic exit_ready_ff
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  localparam int PIN_W = 1 + 4 + sdram_cfg_pkg::BANK_W + sdram_cfg_pkg::ADDR_W + 1;
  localparam logic [PIN_W-1:0] PIN_IDLE = {1'b1, 4'hf, {(PIN_W-5){1'b0}}};

  logic [PIN_W-1:0] pin_meta_ff;  // first stage, read only by the second
  logic [PIN_W-1:0] pin_sync_ff;  // second stage, safe to decode
  sdram_cfg_pkg::cmd_pins_t cmd;
  logic cke;
  logic [sdram_cfg_pkg::BANK_W-1:0] bank;
  logic [sdram_cfg_pkg::ADDR_W-1:0] addr;
  logic term_pin;

  // one two-stage chain keeps all pins aligned
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_meta_ff <= PIN_IDLE;
      pin_sync_ff <= PIN_IDLE;
    end else begin
      pin_meta_ff <= {cke_pin, cmd_pin, bank_pin, addr_pin, termination_control};
      pin_sync_ff <= pin_meta_ff;
    end
  end

  assign {cke, cmd, bank, addr, term_pin} = pin_sync_ff;

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  logic [2:0] cmd_code;  // {ras_n, cas_n, we_n}
  logic cmd_sel;         // chip selected
  logic ready_state;     // idle or active; the clock enable is tested separately
  logic load_cmd;
  logic refresh_cmd;

  assign cmd_code = {cmd.ras_n, cmd.cas_n, cmd.we_n};
  assign cmd_sel = !cmd.cs_n;
  assign ready_state = (pwr_state_ff == sdram_cfg_pkg::ST_IDLE) ||
                       (pwr_state_ff == sdram_cfg_pkg::ST_ACTIVE);
  assign load_cmd = cmd_sel && cke && ready_state && (cmd_code == sdram_cfg_pkg::CMD_LOAD);
  assign refresh_cmd = cmd_sel && (cmd_code == sdram_cfg_pkg::CMD_REFRESH);

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  logic [sdram_cfg_pkg::CFG_W-1:0] base_mode_config_ff;
  logic [sdram_cfg_pkg::CFG_W-1:0] extended_mode_config_ff;
  logic [sdram_cfg_pkg::CFG_W-1:0] load_word;

  assign load_word = {bank, addr};

  // capture at the load edge; other selects ignored
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      base_mode_config_ff <= sdram_cfg_pkg::BASE_RST;
      extended_mode_config_ff <= sdram_cfg_pkg::EXT_RST;
    end else if (load_cmd) begin
      if (bank[1:0] == sdram_cfg_pkg::SEL_BASE) begin
        base_mode_config_ff <= load_word;
        // loop reset is a one-shot, never stored
        base_mode_config_ff[sdram_cfg_pkg::LOOP_RST_BIT] <= 1'b0;
      end else if (bank[1:0] == sdram_cfg_pkg::SEL_EXTENDED) begin
        extended_mode_config_ff <= load_word;
      end
    end
    // otherwise both hold until the next load
  end

  // ---------------------------------------------------------------
  // field decode
  // ---------------------------------------------------------------
  logic [2:0] rl_cyc;     // read latency, whole clocks only
  logic [2:0] add_dly;
  logic [3:0] eff_rl;
  logic [3:0] eff_wl;
  logic [3:0] wrec;
  logic slow_exit;
  logic outs_on;
  logic term_en;

  assign rl_cyc = base_mode_config_ff[sdram_cfg_pkg::RL_CYC_LSB +: 3];
  assign add_dly = extended_mode_config_ff[sdram_cfg_pkg::ADD_DLY_LSB +: 3];
  assign eff_rl = {1'b0, rl_cyc} + {1'b0, add_dly};
  assign eff_wl = eff_rl - 4'h1;
  // code 1..7 maps to 2..8 clocks; reserved codes are not trapped
  assign wrec = {1'b0, base_mode_config_ff[sdram_cfg_pkg::WREC_LSB +: 3]}
              + sdram_cfg_pkg::WREC_OFFSET;
  assign slow_exit = base_mode_config_ff[sdram_cfg_pkg::SLOW_EXIT_BIT];
  assign outs_on = !extended_mode_config_ff[sdram_cfg_pkg::OUT_OFF_BIT];
  assign term_en = extended_mode_config_ff[sdram_cfg_pkg::TERM_HI_BIT] ||
                   extended_mode_config_ff[sdram_cfg_pkg::TERM_LO_BIT];

  // register the decoded fields for the outputs
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mode_fields_ff <= '0;
      term_sel_ff <= sdram_cfg_pkg::TERM_OFF;
    end else begin
      mode_fields_ff.write_recovery_time <= wrec;
      mode_fields_ff.read_latency_cycles <= rl_cyc;
      mode_fields_ff.added_command_delay <= add_dly;
      mode_fields_ff.effective_read_latency <= eff_rl;
      mode_fields_ff.effective_write_latency <= eff_wl;
      mode_fields_ff.slow_exit_sel <= slow_exit;
      // {bit6, bit2}: 01 -> 75, 10 -> 150, 11 -> 50 ohms
      term_sel_ff <= sdram_cfg_pkg::term_sel_t'(
        {extended_mode_config_ff[sdram_cfg_pkg::TERM_HI_BIT],
         extended_mode_config_ff[sdram_cfg_pkg::TERM_LO_BIT]});
    end
  end

  // strobe and driver controls; a disabled output stage gates all but drive_reduced
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      strobe_ctl_ff <= '0;
    end else begin
      strobe_ctl_ff.drive_reduced <=
        extended_mode_config_ff[sdram_cfg_pkg::DRIVE_BIT];
      strobe_ctl_ff.strobe_comp_en <= outs_on &&
        !extended_mode_config_ff[sdram_cfg_pkg::COMP_OFF_BIT];
      strobe_ctl_ff.dup_strobe_en <= outs_on && X8_CONFIG &&
        extended_mode_config_ff[sdram_cfg_pkg::DUP_ON_BIT];
      strobe_ctl_ff.dup_strobe_comp_en <= outs_on && X8_CONFIG &&
        extended_mode_config_ff[sdram_cfg_pkg::DUP_ON_BIT] &&
        !extended_mode_config_ff[sdram_cfg_pkg::COMP_OFF_BIT];
      strobe_ctl_ff.outputs_enabled <= outs_on;
    end
  end

  // ---------------------------------------------------------------
  // open-bank bookkeeping, picks active vs precharge power-down
  // ---------------------------------------------------------------
  logic [7:0] banks_open_ff;
  logic [7:0] nxt_banks_open;

  // auto precharge closes the bank at the command; a rough model
  // used to pick the power-down kind and idle versus active
  always_comb begin
    nxt_banks_open = banks_open_ff;
    if (cmd_sel && cke && ready_state) begin
      case (cmd_code)
        sdram_cfg_pkg::CMD_ACTIVATE: nxt_banks_open[bank] = 1'b1;
        sdram_cfg_pkg::CMD_PRECHARGE: begin
          if (addr[sdram_cfg_pkg::AUTO_PRE_BIT]) begin
            nxt_banks_open = 8'h00;
          end else begin
            nxt_banks_open[bank] = 1'b0;
          end
        end
        sdram_cfg_pkg::CMD_READ, sdram_cfg_pkg::CMD_WRITE: begin
          if (addr[sdram_cfg_pkg::AUTO_PRE_BIT]) begin
            nxt_banks_open[bank] = 1'b0;
          end
        end
        default: nxt_banks_open = banks_open_ff;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      banks_open_ff <= 8'h00;
    end else begin
      banks_open_ff <= nxt_banks_open;
    end
  end

  // ---------------------------------------------------------------
  // power state machine
  // ---------------------------------------------------------------
  sdram_cfg_pkg::pwr_state_t nxt_pwr_state;
  logic [3:0] exit_cnt_ff;
  logic [3:0] nxt_exit_cnt;
  logic sref_exit;  // one clock when self refresh ends

  always_comb begin
    nxt_pwr_state = pwr_state_ff;
    nxt_exit_cnt = exit_cnt_ff;
    sref_exit = 1'b0;
    case (pwr_state_ff)
      sdram_cfg_pkg::ST_IDLE, sdram_cfg_pkg::ST_ACTIVE: begin
        if (!cke && refresh_cmd) begin
          nxt_pwr_state = sdram_cfg_pkg::ST_SELF_REF;
        end else if (!cke) begin
          nxt_pwr_state = (banks_open_ff != 8'h00) ? sdram_cfg_pkg::ST_ACT_PD
                                                  : sdram_cfg_pkg::ST_PRE_PD;
        end else begin
          nxt_pwr_state = (nxt_banks_open != 8'h00) ? sdram_cfg_pkg::ST_ACTIVE
                                                   : sdram_cfg_pkg::ST_IDLE;
        end
      end
      sdram_cfg_pkg::ST_ACT_PD: begin
        if (cke) begin
          nxt_pwr_state = sdram_cfg_pkg::ST_PD_EXIT;
          // exit speed follows bit12 only here
          nxt_exit_cnt = slow_exit ? 4'(SLOW_EXIT) : 4'(FAST_EXIT);
        end
      end
      sdram_cfg_pkg::ST_PRE_PD: begin
        if (cke) begin
          nxt_pwr_state = sdram_cfg_pkg::ST_PD_EXIT;
          nxt_exit_cnt = 4'(FAST_EXIT);  // bit12 ignored
        end
      end
      sdram_cfg_pkg::ST_SELF_REF: begin
        if (cke) begin
          nxt_pwr_state = sdram_cfg_pkg::ST_PD_EXIT;
          nxt_exit_cnt = 4'(FAST_EXIT);
          sref_exit = 1'b1;
        end
      end
      sdram_cfg_pkg::ST_PD_EXIT: begin
        if (exit_cnt_ff <= 4'h1) begin
          nxt_exit_cnt = 4'h0;
          nxt_pwr_state = (banks_open_ff != 8'h00) ? sdram_cfg_pkg::ST_ACTIVE
                                                  : sdram_cfg_pkg::ST_IDLE;
        end else begin
          nxt_exit_cnt = exit_cnt_ff - 4'h1;
        end
      end
      default: nxt_pwr_state = sdram_cfg_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pwr_state_ff <= sdram_cfg_pkg::ST_IDLE;
      exit_cnt_ff <= 4'h0;
      exit_ready_ff <= 1'b1;
    end else begin
      pwr_state_ff <= nxt_pwr_state;
      exit_cnt_ff <= nxt_exit_cnt;
      exit_ready_ff <= (nxt_pwr_state == sdram_cfg_pkg::ST_IDLE) ||
                       (nxt_pwr_state == sdram_cfg_pkg::ST_ACTIVE);
    end
  end

  // ---------------------------------------------------------------
  // clock-alignment loop control
  // ---------------------------------------------------------------
  // extended bit0 low keeps the loop on; self refresh turns it off and
  // its exit forces a fresh reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      loop_enabled_ff <= 1'b0;
      loop_running_ff <= 1'b0;
      loop_reset_ff <= 1'b0;
    end else begin
      loop_enabled_ff <= !extended_mode_config_ff[sdram_cfg_pkg::LOOP_OFF_BIT] &&
                         (nxt_pwr_state != sdram_cfg_pkg::ST_SELF_REF);
      // slow-exit active power-down freezes it fast keeps it
      loop_running_ff <= !extended_mode_config_ff[sdram_cfg_pkg::LOOP_OFF_BIT] &&
                         (nxt_pwr_state != sdram_cfg_pkg::ST_SELF_REF) &&
                         !((nxt_pwr_state == sdram_cfg_pkg::ST_ACT_PD) && slow_exit);
      loop_reset_ff <= sref_exit ||
        (load_cmd && (bank[1:0] == sdram_cfg_pkg::SEL_BASE) &&
         addr[sdram_cfg_pkg::LOOP_RST_BIT]);
    end
  end

  // ---------------------------------------------------------------
  // termination switching
  // ---------------------------------------------------------------
  logic term_state_ok;

  assign term_state_ok = (pwr_state_ff == sdram_cfg_pkg::ST_ACTIVE) ||
                         (pwr_state_ff == sdram_cfg_pkg::ST_ACT_PD) ||
                         (pwr_state_ff == sdram_cfg_pkg::ST_PRE_PD);

  // the pin only switches a value that has been selected
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      termination_on_ff <= 1'b0;
    end else begin
      termination_on_ff <= term_en && term_pin && term_state_ok;
    end
  end

  // ---------------------------------------------------------------
  // read data timing and write auto precharge timing
  // ---------------------------------------------------------------
  localparam int SEL_W = $clog2(sdram_cfg_pkg::DELAY_DEPTH);

  logic read_issue;
  logic write_ap_issue;
  logic [SEL_W-1:0] read_dly;
  logic [SEL_W-1:0] ap_dly;
  logic read_start;
  logic ap_fire;

  assign read_issue = cmd_sel && cke && ready_state && (cmd_code == sdram_cfg_pkg::CMD_READ);
  assign write_ap_issue = cmd_sel && cke && ready_state &&
                          (cmd_code == sdram_cfg_pkg::CMD_WRITE) &&
                          addr[sdram_cfg_pkg::AUTO_PRE_BIT];
  // first read data lands a whole number of clocks after the command
  assign read_dly = SEL_W'(eff_rl);
  // write latency plus burst, then write recovery before the precharge
  assign ap_dly = SEL_W'(eff_wl) + SEL_W'(sdram_cfg_pkg::BURST_CYC) + SEL_W'(wrec);

  pulse_delay_line #(
    .DEPTH(sdram_cfg_pkg::DELAY_DEPTH)
  ) u_read_delay (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pulse_in(read_issue),
    .sel_delay(read_dly),
    .pulse_out(read_start)
  );

  pulse_delay_line #(
    .DEPTH(sdram_cfg_pkg::DELAY_DEPTH)
  ) u_ap_delay (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pulse_in(write_ap_issue),
    .sel_delay(ap_dly),
    .pulse_out(ap_fire)
  );

  // ---------------------------------------------------------------
  // read strobe window
  // ---------------------------------------------------------------
  logic [2:0] burst_cnt_ff;

  // a new read start restarts the window; back-to-back reads stay seamless
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      burst_cnt_ff <= 3'h0;
    end else if (read_start) begin
      burst_cnt_ff <= 3'(sdram_cfg_pkg::BURST_CYC);
    end else if (burst_cnt_ff != 3'h0) begin
      burst_cnt_ff <= burst_cnt_ff - 3'h1;
    end
  end

  // registered pulses and strobe drives
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      read_data_start_ff <= 1'b0;
      auto_precharge_ff <= 1'b0;
      strobe_drive_ff <= 1'b0;
      dup_strobe_drive_ff <= 1'b0;
    end else begin
      read_data_start_ff <= read_start;
      auto_precharge_ff <= ap_fire;
      strobe_drive_ff <= outs_on && (read_start || burst_cnt_ff > 3'h1);
      // reads only: a write never drives the duplicate strobe
      dup_strobe_drive_ff <= outs_on && X8_CONFIG &&
        extended_mode_config_ff[sdram_cfg_pkg::DUP_ON_BIT] &&
        (read_start || burst_cnt_ff > 3'h1);
    end
  end

endmodule

`default_nettype wire

// *** tb/sdram_cfg_monitor.sv ***
`default_nettype none
// ---------------------------------------------------------------
// checker on the config decode ports
// ---------------------------------------------------------------
module sdram_cfg_monitor #(
  parameter int FAST_EXIT = 2,
  parameter int SLOW_EXIT = 6
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire sdram_cfg_pkg::mode_fields_t mode_fields_ff,
  input wire sdram_cfg_pkg::strobe_ctl_t strobe_ctl_ff,
  input wire sdram_cfg_pkg::term_sel_t term_sel_ff,
  input wire logic termination_on_ff,
  input wire logic loop_enabled_ff,
  input wire logic loop_reset_ff,
  input wire logic read_data_start_ff,
  input wire logic strobe_drive_ff,
  input wire logic dup_strobe_drive_ff,
  input wire sdram_cfg_pkg::pwr_state_t pwr_state_ff,
  input wire logic exit_ready_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // short names
  logic in_exit, in_sr, in_apd, in_ppd;
  sdram_cfg_pkg::mode_fields_t m;
  sdram_cfg_pkg::strobe_ctl_t s;
  assign m = mode_fields_ff;
  assign s = strobe_ctl_ff;
  assign in_exit = pwr_state_ff == sdram_cfg_pkg::ST_PD_EXIT;
  assign in_sr = pwr_state_ff == sdram_cfg_pkg::ST_SELF_REF;
  assign in_apd = pwr_state_ff == sdram_cfg_pkg::ST_ACT_PD;
  assign in_ppd = pwr_state_ff == sdram_cfg_pkg::ST_PRE_PD;
  a_loop_reset_pulse: assert property (loop_reset_ff |=> !loop_reset_ff)
    else $error("loop reset wider than one cycle");
  a_dup_comp_both: assert property (s.dup_strobe_comp_en == (s.dup_strobe_en && s.strobe_comp_en))
    else $error("duplicate complement enable wrong");
  a_outputs_gated: assert property (!s.outputs_enabled |-> !strobe_drive_ff && !dup_strobe_drive_ff)
    else $error("strobe driven while outputs disabled");
  a_read_strobe_win: assert property (read_data_start_ff && s.outputs_enabled |-> strobe_drive_ff ##1 strobe_drive_ff)
    else $error("read strobe window wrong");
  a_dup_follows_read: assert property (dup_strobe_drive_ff |-> strobe_drive_ff && s.dup_strobe_en)
    else $error("duplicate strobe outside read window");
  a_latency_sum: assert property (m.effective_read_latency != 4'h0 |->
    m.effective_read_latency == 4'(m.read_latency_cycles) + 4'(m.added_command_delay)
    && m.effective_write_latency == m.effective_read_latency - 4'h1)
    else $error("effective latency sum wrong");
  a_term_needs_value: assert property (termination_on_ff |-> term_sel_ff != sdram_cfg_pkg::TERM_OFF)
    else $error("termination on with no value");
  a_self_ref_quiet: assert property (in_sr [*2] |-> !termination_on_ff && !loop_enabled_ff)
    else $error("termination or loop active in self refresh");
  a_slow_exit_len: assert property ($past(in_apd) && in_exit && m.slow_exit_sel |-> in_exit [*5])
    else $error("slow exit too short");
  a_pre_pd_fast: assert property ($past(in_ppd) && in_exit |-> ##[1:3] exit_ready_ff)
    else $error("precharge power-down exit not fast");
endmodule
bind sdram_mode_config_decode sdram_cfg_monitor #(.FAST_EXIT(FAST_EXIT), .SLOW_EXIT(SLOW_EXIT)) u_mon (
  .ref_clk, .rst_n, .mode_fields_ff, .strobe_ctl_ff, .term_sel_ff, .termination_on_ff,
  .loop_enabled_ff, .loop_reset_ff, .read_data_start_ff, .strobe_drive_ff,
  .dup_strobe_drive_ff, .pwr_state_ff, .exit_ready_ff);
`default_nettype wire

// *** tb/ddr2_ctrl_model.sv ***
`default_nettype none
// ---------------------------------------------------------------
// controller model: one command a call, then the waits it owes
// ---------------------------------------------------------------
module ddr2_ctrl_model #(
  parameter int GAP = 2  // extra config load gap in clocks, on top of the fixed 8
) (
  input wire logic ref_clk,
  output sdram_cfg_pkg::cmd_pins_t cmd_pin,
  output logic [2:0] bank_pin,
  output logic [13:0] addr_pin,
  output logic cke_pin,
  output logic termination_control
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmd_pin = 4'hf;
    bank_pin = 3'h0;
    addr_pin = 14'h0000;
    cke_pin = 1'b1;
    termination_control = 1'b0;
  end
  // loop always enabled: no precharge-all after refresh
  task automatic issue(input logic [2:0] c, input logic [2:0] b, input logic [13:0] a,
                       input logic k);
    @(posedge ref_clk);
    #1;
    cmd_pin = {1'b0, c};
    bank_pin = b;
    addr_pin = a;
    cke_pin = k;
    @(posedge ref_clk);
    #1;
    cmd_pin = 4'h7;
    bank_pin = ~b;  // address lines do not hold past the command
    addr_pin = ~a;
    if (c == sdram_cfg_pkg::CMD_LOAD) begin
      repeat (GAP + 8) @(posedge ref_clk);
      if (b == 3'h0 && a[8]) repeat (200) @(posedge ref_clk);
      #1;
    end
  endtask
  // clock enable and termination levels, turned off before self refresh
  task automatic pins(input logic k, input logic t);
    @(posedge ref_clk);
    #1;
    cke_pin = k;
    termination_control = t;
  endtask
endmodule
`default_nettype wire

// *** tb/sdram_mode_config_decode_bench.sv ***
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fail_count++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module sdram_mode_config_decode_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  sdram_cfg_pkg::cmd_pins_t cmd_pin;
  logic [2:0] bank_pin;
  logic [13:0] addr_pin;
  logic cke_pin, termination_control, loop_enabled_ff, loop_running_ff, loop_reset_ff;
  logic auto_precharge_ff, read_data_start_ff, strobe_drive_ff, dup_strobe_drive_ff;
  logic termination_on_ff, exit_ready_ff;
  sdram_cfg_pkg::mode_fields_t mode_fields_ff;
  sdram_cfg_pkg::strobe_ctl_t strobe_ctl_ff;
  sdram_cfg_pkg::term_sel_t term_sel_ff;
  sdram_cfg_pkg::pwr_state_t pwr_state_ff;
  int fail_count = 0, n_compared = 0, cyc = 0, n_lrst = 0, n;
  initial forever #2.5 ref_clk = ~ref_clk;
  sdram_mode_config_decode u_sdram_mode_config_decode (.ref_clk, .rst_n, .cke_pin, .cmd_pin,
    .bank_pin, .addr_pin, .termination_control, .mode_fields_ff, .strobe_ctl_ff, .term_sel_ff,
    .termination_on_ff, .loop_enabled_ff, .loop_running_ff, .loop_reset_ff, .auto_precharge_ff,
    .read_data_start_ff, .strobe_drive_ff, .dup_strobe_drive_ff, .pwr_state_ff, .exit_ready_ff);
  ddr2_ctrl_model u_ctrl (.ref_clk, .cmd_pin, .bank_pin, .addr_pin, .cke_pin,
    .termination_control);
  // loop reset pulses and a hang guard
  always @(negedge ref_clk) begin
    cyc++;
    if (loop_reset_ff === 1'b1) n_lrst++;
    if (cyc == 5000) begin
      fail_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (fail_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // wait k edges, then step off the edge so outputs have settled
  task automatic w(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  // clocks until the chosen pulse
  task automatic lat(input bit rd);
    n = 0;
    do begin
      w(1);
      n++;
    end while ((rd ? read_data_start_ff : auto_precharge_ff) !== 1'b1 && n < 40);
  endtask
  // cl 5, wr 4 (legal codes), slow exit, loop reset; then rtt 75, al 2
  task automatic t_cfg();
    u_ctrl.issue(sdram_cfg_pkg::CMD_LOAD, 3'h0, 14'h1750, 1'b1);
    `CHK(mode_fields_ff.read_latency_cycles, 3'h5)
    `CHK(mode_fields_ff.write_recovery_time, 4'h4)
    `CHK(n_lrst, 1)
    u_ctrl.issue(sdram_cfg_pkg::CMD_LOAD, 3'h1, 14'h0816, 1'b1);
    `CHK(strobe_ctl_ff, 5'h1f)
    `CHK(term_sel_ff, sdram_cfg_pkg::TERM_75)
    `CHK({mode_fields_ff.effective_read_latency, mode_fields_ff.effective_write_latency}, 8'h76)
  endtask
  // termination pin across states
  task automatic t_term_pd();
    u_ctrl.pins(1'b1, 1'b1);
    w(4);
    `CHK(termination_on_ff, 1'b0)
    u_ctrl.issue(sdram_cfg_pkg::CMD_ACTIVATE, 3'h0, 14'h0000, 1'b1);
    w(4);
    `CHK(termination_on_ff, 1'b1)
    u_ctrl.pins(1'b0, 1'b1);
    w(4);
    `CHK(pwr_state_ff, sdram_cfg_pkg::ST_ACT_PD)
    `CHK({loop_running_ff, termination_on_ff}, 2'h1)
    u_ctrl.pins(1'b1, 1'b0);
    w(10);
    `CHK(exit_ready_ff, 1'b1)
  endtask
  // read, write auto precharge, power-down, self refresh
  task automatic t_rw_sr();
    u_ctrl.issue(sdram_cfg_pkg::CMD_READ, 3'h0, 14'h0000, 1'b1);
    lat(1'b1);
    `CHK(n, 9)
    `CHK(dup_strobe_drive_ff, 1'b1)
    u_ctrl.issue(sdram_cfg_pkg::CMD_WRITE, 3'h0, 14'h0400, 1'b1);
    lat(1'b0);
    `CHK(n, 14)
    u_ctrl.pins(1'b0, 1'b0);
    w(4);
    `CHK(pwr_state_ff, sdram_cfg_pkg::ST_PRE_PD)
    u_ctrl.pins(1'b1, 1'b0);
    w(10);
    u_ctrl.issue(sdram_cfg_pkg::CMD_REFRESH, 3'h0, 14'h0000, 1'b0);
    w(4);
    `CHK(loop_enabled_ff, 1'b0)
    u_ctrl.pins(1'b1, 1'b0);
    w(12);
    `CHK(n_lrst, 2)
  endtask
  // outputs off; base fields survive
  task automatic t_outdis();
    u_ctrl.issue(sdram_cfg_pkg::CMD_LOAD, 3'h1, 14'h1c16, 1'b1);
    `CHK(strobe_ctl_ff, 5'h10)
    `CHK(mode_fields_ff.read_latency_cycles, 3'h5)
    u_ctrl.issue(sdram_cfg_pkg::CMD_ACTIVATE, 3'h0, 14'h0000, 1'b1);
    u_ctrl.issue(sdram_cfg_pkg::CMD_READ, 3'h0, 14'h0000, 1'b1);
    lat(1'b1);
    `CHK({n[3:0], strobe_drive_ff}, 5'h12)
  endtask
  initial begin
    w(16);
    rst_n = 1'b1;
    t_cfg();
    t_term_pd();
    t_rw_sr();
    t_outdis();
    end_of_test();
  end
endmodule
`default_nettype wire
